// file: fcd_host.sv
/*
 flash command host: takes orders over APB and drives a parallel NOR flash
 through its pins with one- and multi-cycle command sequences.
 assumes flash inputs synchronous to pclk and an always-ready APB master.
*/
// Added by the designer: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
// Function
// RULE_01: alter operations only with program enable level
// RULE_02: FFH write returns device to array
// RULE_03: 90H then reads return identifier codes
// RULE_04: 98H then reads return query bytes
// RULE_05: 70H then read returns status
// RULE_06: 50H clears status error bits
// RULE_07: E8H, check extended status, then count
// RULE_08: count N means N plus one writes
// RULE_09: confirm D0H after exactly N plus one
// RULE_10: nothing starts before the confirm code
// RULE_11: 40H or 10H, then address and data
// RULE_12: erase is 20H then D0H in block
// RULE_13: B0H suspends, D0H resumes
// RULE_14: B8H then configuration code write
// RULE_15: 60H 01H sets one block lock
// RULE_16: 60H D0H clears all block locks
// RULE_17: locked block alters need reset high voltage
// RULE_18: while busy only bit 7 is valid
// RULE_19: upper data byte ignored on commands
// RULE_20: after reset device is in array mode
// RULE_21: array read ignored while operation runs
// RULE_22: only defined command codes are issued
// RULE_23: busy output low while algorithms run
// RULE_24: bad second cycle is a sequence error
module fcd_host import fcd_pkg::*; #(
   parameter int BUF_DEPTH = 32,
   parameter int XSR_TRIES = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output fcd_pins_t flash_out,
   input wire logic [FL_DATA_W-1:0] flash_dq_i,
   input wire logic flash_sts
);
   localparam int IDX_W = $clog2(BUF_DEPTH);
   if (BUF_DEPTH < 16 || BUF_DEPTH > 32 || XSR_TRIES < 1 || XSR_TRIES > 15) begin : g_bad_param
      $error("fcd_host: unsupported parameter values");
   end

   logic [15:0] buf_mem [BUF_DEPTH];
   fcd_seq_t seq_reg, seq_next;
   fcd_op_t op_reg;
   fcd_mode_t mode_reg;
   logic [3:0] tmr_reg;
   logic [3:0] pins_reg;
   logic [FL_ADDR_W-1:0] addr_reg;
   logic [15:0] data_reg;
   logic [15:0] rdata_reg;
   logic [4:0] idx_reg, idx_next;
   logic [3:0] tries_reg;
   logic [FL_ADDR_W-1:0] cyc_addr_reg;
   logic [15:0] cyc_data_reg;
   logic susp_reg, done_reg, refused_reg, xsr_err_reg;
   logic wr_en, rd_en, go, go_ok, alter_op, rd_state, cyc_end, sample;
   logic [4:0] count_max;
   logic [7:0] cmd_code;
   fcd_op_t go_op;

   assign pready = 1'b1;
   assign wr_en = psel && penable && pwrite;
   assign rd_en = psel && penable && !pwrite;
   assign go = wr_en && paddr == REG_CTRL && pwdata[CTRL_GO_BIT];
   assign go_op = fcd_op_t'(pwdata[3:0]);
   assign count_max = pins_reg[PIN_BYTE_BIT] ? COUNT_MAX_BYTE : COUNT_MAX_WORD;
   assign alter_op = go_op inside {OP_BUF_WRITE, OP_PROGRAM, OP_ERASE, OP_LOCK_SET, OP_LOCK_CLR};
   assign go_ok = go && seq_reg == S_IDLE && !pins_reg[PIN_RPLOW_BIT]
      && pwdata[3:0] <= OP_BUS_READ // [RULE_22]
      && !(alter_op && !pins_reg[PIN_PROGRAM_ENABLE_SUPPLY_BIT]) // [RULE_01]
      && !(go_op == OP_RD_ARRAY && !flash_sts && !susp_reg) // [RULE_21]
      && !(go_op == OP_BUF_WRITE && (data_reg[4:0] > count_max || 32'(data_reg[4:0]) >= BUF_DEPTH)); // [RULE_08]
   assign rd_state = seq_reg == S_XSR || seq_reg == S_READ;
   assign cyc_end = seq_reg != S_IDLE && tmr_reg == (rd_state ? RD_LAST : WR_LAST);
   assign sample = rd_state && tmr_reg == RD_SAMPLE;

   // first-cycle code per operation
   always_comb begin
      case (op_reg)
         OP_RD_ARRAY: cmd_code = CMD_READ_ARRAY; // [RULE_02]
         OP_RD_ID: cmd_code = CMD_READ_ID; // [RULE_03]
         OP_RD_QUERY: cmd_code = CMD_READ_QUERY; // [RULE_04]
         OP_RD_STATUS: cmd_code = CMD_READ_STATUS; // [RULE_05]
         OP_CLR_STATUS: cmd_code = CMD_CLR_STATUS; // [RULE_06]
         OP_BUF_WRITE: cmd_code = CMD_BUF_WRITE; // [RULE_07]
         OP_PROGRAM: cmd_code = CMD_PROGRAM; // [RULE_11]
         OP_ERASE: cmd_code = CMD_ERASE; // [RULE_12]
         OP_SUSPEND: cmd_code = CMD_SUSPEND; // [RULE_13]
         OP_RESUME: cmd_code = CMD_CONFIRM; // [RULE_13]
         OP_CONFIG: cmd_code = CMD_CONFIG; // [RULE_14]
         default: cmd_code = CMD_LOCK;
      endcase
   end

   // sequencer step order
   always_comb begin
      seq_next = seq_reg;
      idx_next = idx_reg;
      case (seq_reg)
         S_IDLE: begin
            if (go_ok) begin
               seq_next = go_op == OP_BUS_READ ? S_READ : S_CMD1;
            end
         end
         S_CMD1: begin
            if (cyc_end) begin
               case (op_reg)
                  OP_RD_ID, OP_RD_QUERY, OP_RD_STATUS: seq_next = S_READ;
                  OP_BUF_WRITE: seq_next = S_XSR; // [RULE_07]
                  OP_PROGRAM, OP_ERASE, OP_CONFIG, OP_LOCK_SET, OP_LOCK_CLR: seq_next = S_ARG;
                  default: seq_next = S_IDLE;
               endcase
            end
         end
         S_XSR: begin
            if (cyc_end) begin
               if (rdata_reg[XSR_READY_BIT]) begin
                  seq_next = S_COUNT; // [RULE_07]
               end else begin
                  seq_next = tries_reg == 4'(XSR_TRIES - 1) ? S_IDLE : S_CMD1;
               end
            end
         end
         S_COUNT: begin
            if (cyc_end) begin
               seq_next = S_DATA;
               idx_next = 5'h0;
            end
         end
         S_DATA: begin
            if (cyc_end) begin
               if (idx_reg == data_reg[4:0]) begin
                  seq_next = S_CONF; // [RULE_09]
               end else begin
                  idx_next = idx_reg + 5'h1; // [RULE_08]
               end
            end
         end
         S_CONF, S_ARG, S_READ: begin
            if (cyc_end) begin
               seq_next = S_IDLE;
            end
         end
         default: seq_next = S_IDLE;
      endcase
   end

   // address and data of the coming bus cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cyc_addr_reg <= '0;
         cyc_data_reg <= '0;
      end else if (seq_next != seq_reg || cyc_end) begin
         cyc_addr_reg <= addr_reg;
         case (seq_next)
            S_CMD1: cyc_data_reg <= {8'h00, cmd_code_of(go_ok ? go_op : op_reg)}; // [RULE_19]
            S_COUNT: cyc_data_reg <= {11'h000, data_reg[4:0]}; // [RULE_08]
            S_DATA: cyc_data_reg <= buf_mem[IDX_W'(idx_next)];
            S_CONF: cyc_data_reg <= {8'h00, CMD_CONFIRM}; // [RULE_10]
            S_ARG: begin
               case (op_reg)
                  OP_ERASE, OP_LOCK_CLR: cyc_data_reg <= {8'h00, CMD_CONFIRM}; // [RULE_12] [RULE_16]
                  OP_LOCK_SET: cyc_data_reg <= {8'h00, CMD_LOCK_SET}; // [RULE_15]
                  OP_CONFIG: cyc_data_reg <= {8'h00, data_reg[7:0]}; // [RULE_14]
                  default: cyc_data_reg <= data_reg; // [RULE_11]
               endcase
            end
            default: cyc_data_reg <= '0;
         endcase
      end
   end

   function automatic logic [7:0] cmd_code_of(input fcd_op_t op);
      logic [7:0] c;
      c = CMD_LOCK;
      case (op)
         OP_RD_ARRAY: c = CMD_READ_ARRAY;
         OP_RD_ID: c = CMD_READ_ID;
         OP_RD_QUERY: c = CMD_READ_QUERY;
         OP_RD_STATUS: c = CMD_READ_STATUS;
         OP_CLR_STATUS: c = CMD_CLR_STATUS;
         OP_BUF_WRITE: c = CMD_BUF_WRITE;
         OP_PROGRAM: c = CMD_PROGRAM;
         OP_ERASE: c = CMD_ERASE;
         OP_SUSPEND: c = CMD_SUSPEND;
         OP_RESUME: c = CMD_CONFIRM;
         OP_CONFIG: c = CMD_CONFIG;
         default: c = CMD_LOCK;
      endcase
      return c;
   endfunction : cmd_code_of

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         seq_reg <= S_IDLE;
         tmr_reg <= 4'h0;
         idx_reg <= 5'h0;
         op_reg <= OP_RD_ARRAY;
      end else begin
         seq_reg <= seq_next;
         idx_reg <= idx_next;
         tmr_reg <= (seq_next != seq_reg || cyc_end) ? 4'h0 : tmr_reg + 4'h1;
         if (go_ok) begin
            op_reg <= go_op;
         end
      end
   end

   // retries of the buffer availability check
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tries_reg <= 4'h0;
      end else if (go_ok) begin
         tries_reg <= 4'h0;
      end else if (seq_reg == S_XSR && cyc_end) begin
         tries_reg <= tries_reg + 4'h1;
      end
   end

   // read capture; busy device drives bit 7 only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdata_reg <= '0;
      end else if (sample) begin
         rdata_reg <= flash_sts ? flash_dq_i : {8'h00, flash_dq_i[STATUS_VALID_BIT], 7'h00}; // [RULE_18]
      end
   end

   // device read mode and suspend tracking
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_reg <= MODE_ARRAY;
         susp_reg <= 1'b0;
      end else if (pins_reg[PIN_RPLOW_BIT]) begin
         mode_reg <= MODE_ARRAY; // [RULE_20]
         susp_reg <= 1'b0;
      end else if (seq_reg == S_CMD1 && cyc_end) begin
         case (op_reg)
            OP_RD_ARRAY: mode_reg <= MODE_ARRAY;
            OP_RD_ID: mode_reg <= MODE_ID;
            OP_RD_QUERY: mode_reg <= MODE_QUERY;
            OP_CLR_STATUS, OP_CONFIG: mode_reg <= mode_reg;
            default: mode_reg <= MODE_STATUS;
         endcase
         if (op_reg == OP_SUSPEND) begin
            susp_reg <= 1'b1; // [RULE_13]
         end else if (op_reg == OP_RESUME) begin
            susp_reg <= 1'b0;
         end
      end
   end

   // sticky outcome flags; a sequence end beats a refused go in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         done_reg <= 1'b0;
         refused_reg <= 1'b0;
         xsr_err_reg <= 1'b0;
      end else begin
         if (go) begin
            refused_reg <= !go_ok;
         end
         if (cyc_end && seq_next == S_IDLE) begin
            done_reg <= 1'b1;
            xsr_err_reg <= seq_reg == S_XSR;
         end else if (go) begin
            done_reg <= 1'b0;
            xsr_err_reg <= 1'b0;
         end
      end
   end

   // software registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pins_reg <= PINS_RESET;
         addr_reg <= '0;
         data_reg <= '0;
      end else if (wr_en) begin
         case (paddr)
            REG_PINS: pins_reg <= pwdata[3:0];
            REG_ADDR: addr_reg <= pwdata[FL_ADDR_W-1:0];
            REG_DATA: data_reg <= pwdata[15:0];
            default: pins_reg <= pins_reg;
         endcase
      end
   end

   // program buffer words, one aligned word each
   for (genvar i = 0; i < BUF_DEPTH; i++) begin : g_buf
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            buf_mem[i] <= '0;
         end else if (wr_en && paddr == REG_BUF + 8'(4 * i)) begin
            buf_mem[i] <= pwdata[15:0];
         end
      end
   end

   logic buf_hit;
   assign buf_hit = paddr >= REG_BUF && paddr < REG_BUF + 8'(4 * BUF_DEPTH) && paddr[1:0] == 2'b00;
   always_comb begin
      prdata = 32'h0000_0000;
      pslverr = 1'b0;
      case (paddr)
         REG_CTRL: prdata = {28'h000_0000, op_reg};
         REG_PINS: prdata = {28'h000_0000, pins_reg};
         REG_ADDR: prdata = 32'(addr_reg);
         REG_DATA: prdata = {16'h0000, data_reg};
         REG_RDATA: prdata = {16'h0000, rdata_reg};
         REG_STATUS: prdata = {20'h0_0000, 2'(mode_reg), 4'h0, susp_reg, flash_sts, xsr_err_reg, refused_reg,
            done_reg, seq_reg != S_IDLE};
         default: begin
            if (buf_hit) begin
               prdata = {16'h0000, buf_mem[IDX_W'(paddr[7:2] - REG_BUF[7:2])]};
            end else begin
               pslverr = psel && penable;
            end
         end
      endcase
   end

   // pins: write latched by the flash at the rising write strobe
   always_comb begin
      flash_out.addr = cyc_addr_reg;
      flash_out.ce_n = seq_reg == S_IDLE;
      flash_out.oe_n = !(rd_state && tmr_reg < 4'(ACC_CYC));
      flash_out.we_n = !(seq_reg != S_IDLE && !rd_state && tmr_reg < WP_END); // [RULE_11]
      flash_out.byte_n = !pins_reg[PIN_BYTE_BIT];
      flash_out.rp_n = !pins_reg[PIN_RPLOW_BIT];
      flash_out.rp_hv = pins_reg[PIN_RPHV_BIT]; // [RULE_15] [RULE_16] [RULE_17]
      flash_out.program_enable_supply_hv = pins_reg[PIN_PROGRAM_ENABLE_SUPPLY_BIT]; // [RULE_01]
      flash_out.dq_o = cyc_data_reg;
      flash_out.dq_oe = seq_reg != S_IDLE && !rd_state;
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_erase_setup;
      seq_reg == S_CMD1 && op_reg == OP_ERASE && cyc_end;
   endsequence
   sequence s_erase_confirm;
      seq_reg == S_ARG && flash_out.dq_o[7:0] == CMD_CONFIRM;
   endsequence

   a_alter_needs_program_enable_supply: assert property (go_ok && alter_op |-> flash_out.program_enable_supply_hv) // [RULE_01]
      else $error("alter order accepted without program enable");
   a_array_code: assert property (seq_reg == S_CMD1 && op_reg == OP_RD_ARRAY |-> cyc_data_reg == 16'h00FF) // [RULE_02]
      else $error("array read code wrong");
   a_id_then_read: assert property (seq_reg == S_CMD1 && op_reg == OP_RD_ID && cyc_end |=> seq_reg == S_READ) // [RULE_03]
      else $error("identifier read not followed by read cycle");
   a_busy_mask: assert property (sample && !flash_sts |=> rdata_reg[15:8] == 8'h00 && rdata_reg[6:0] == 7'h00) // [RULE_18]
      else $error("busy read kept invalid bits");
   a_upper_byte_zero: assert property (seq_reg == S_CMD1 |-> flash_out.dq_o == {8'h00, cmd_code}) // [RULE_19]
      else $error("command write upper byte not zero");
   a_confirm_count: assert property (seq_reg == S_DATA && seq_next == S_CONF |-> idx_reg == data_reg[4:0]) // [RULE_09]
      else $error("confirm issued after wrong data count");
   a_array_refused: assert property (go && go_op == OP_RD_ARRAY && !flash_sts && !susp_reg |=> seq_reg == S_IDLE // [RULE_21]
      && refused_reg)
      else $error("array read issued during busy operation");
   a_erase_confirm: assert property (s_erase_setup |=> s_erase_confirm [*2]) // [RULE_12]
      else $error("erase setup not followed by confirm");
   a_reset_array: assert property (pins_reg[PIN_RPLOW_BIT] |=> mode_reg == MODE_ARRAY && !susp_reg) // [RULE_20]
      else $error("mode not array after reset pin");
   a_we_pulse: assert property ($rose(flash_out.we_n) |-> flash_out.dq_oe && !flash_out.ce_n) // [RULE_11]
      else $error("write strobe rose without data driven");
endmodule : fcd_host

// file: fcd_pkg.sv
/*
 package of the flash command host: command codes, register map, field
 positions, bus timing and the pin carrier.
 assumes a 25 MHz pclk and a 16-bit flash data bus with 23 address lines.
*/
package fcd_pkg;
   localparam int FL_ADDR_W = 23;
   localparam int FL_DATA_W = 16;
   // command codes
   localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
   localparam logic [7:0] CMD_READ_ID = 8'h90;
   localparam logic [7:0] CMD_READ_QUERY = 8'h98;
   localparam logic [7:0] CMD_READ_STATUS = 8'h70;
   localparam logic [7:0] CMD_CLR_STATUS = 8'h50;
   localparam logic [7:0] CMD_BUF_WRITE = 8'hE8;
   localparam logic [7:0] CMD_PROGRAM = 8'h40;
   localparam logic [7:0] CMD_ERASE = 8'h20;
   localparam logic [7:0] CMD_CONFIRM = 8'hD0;
   localparam logic [7:0] CMD_SUSPEND = 8'hB0;
   localparam logic [7:0] CMD_CONFIG = 8'hB8;
   localparam logic [7:0] CMD_LOCK = 8'h60;
   localparam logic [7:0] CMD_LOCK_SET = 8'h01;
   localparam logic [4:0] COUNT_MAX_BYTE = 5'h1F;
   localparam logic [4:0] COUNT_MAX_WORD = 5'h0F;
   localparam int XSR_READY_BIT = 7;
   localparam int STATUS_VALID_BIT = 7;
   // register byte offsets
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_PINS = 8'h04;
   localparam logic [7:0] REG_ADDR = 8'h08;
   localparam logic [7:0] REG_DATA = 8'h0C;
   localparam logic [7:0] REG_RDATA = 8'h10;
   localparam logic [7:0] REG_STATUS = 8'h14;
   localparam logic [7:0] REG_BUF = 8'h40;
   localparam int CTRL_GO_BIT = 8;
   localparam logic [3:0] PINS_RESET = 4'h0;
   localparam int PIN_PROGRAM_ENABLE_SUPPLY_BIT = 0;
   localparam int PIN_RPHV_BIT = 1;
   localparam int PIN_BYTE_BIT = 2;
   localparam int PIN_RPLOW_BIT = 3;
   // bus cycle timing
   localparam int CLK_MHZ = 25;
   localparam int T_WP_NS = 70;
   localparam int T_ACC_NS = 150;
   localparam int T_REC_NS = 30;
   localparam int WP_CYC = (T_WP_NS * CLK_MHZ + 999) / 1000;
   localparam int ACC_CYC = (T_ACC_NS * CLK_MHZ + 999) / 1000;
   localparam int REC_CYC = (T_REC_NS * CLK_MHZ + 999) / 1000;
   localparam logic [3:0] WR_LAST = 4'(WP_CYC + REC_CYC - 1);
   localparam logic [3:0] RD_LAST = 4'(ACC_CYC + REC_CYC - 1);
   localparam logic [3:0] RD_SAMPLE = 4'(ACC_CYC - 1);
   localparam logic [3:0] WP_END = 4'(WP_CYC);

   typedef enum logic [3:0] {
      OP_RD_ARRAY, OP_RD_ID, OP_RD_QUERY, OP_RD_STATUS, OP_CLR_STATUS, OP_BUF_WRITE, OP_PROGRAM,
      OP_ERASE, OP_SUSPEND, OP_RESUME, OP_CONFIG, OP_LOCK_SET, OP_LOCK_CLR, OP_BUS_READ
   } fcd_op_t;
   typedef enum {S_IDLE, S_CMD1, S_XSR, S_COUNT, S_DATA, S_CONF, S_ARG, S_READ} fcd_seq_t;
   typedef enum logic [1:0] {MODE_ARRAY, MODE_ID, MODE_QUERY, MODE_STATUS} fcd_mode_t;

   typedef struct packed {
      logic [FL_ADDR_W-1:0] addr;
      logic ce_n;
      logic oe_n;
      logic we_n;
      logic byte_n;
      logic rp_n;
      logic rp_hv;
      logic program_enable_supply_hv;
      logic [FL_DATA_W-1:0] dq_o;
      logic dq_oe;
   } fcd_pins_t;
endpackage : fcd_pkg

// file: fcd_flash_model.sv
/*
 behavioural flash device facing the host: decodes command writes, answers
 reads by mode, runs a timed busy period for alter operations.
 assumes pin changes synchronous to pclk, as the host drives them.
*/
`timescale 1ns/1ps
module fcd_flash_model import fcd_pkg::*; #(
   parameter int BUSY_CYC = 120,
   parameter logic [5:0] LOCK_BLK = 6'h01,
   parameter logic [15:0] ID_CODE = 16'h003C // arbitrary value
) (
   input wire logic pclk,
   input wire fcd_pins_t pins,
   output logic [FL_DATA_W-1:0] dq,
   output logic sts
);
   fcd_mode_t mode = MODE_ARRAY; // array mode from power-up
   logic we_q = 1'b1, oe_q = 1'b1, susp = 1'b0, err = 1'b0, rdy;
   logic [7:0] cmd1 = 8'h00, cmd2 = 8'h00, pend = 8'h00, cfg = 8'h00;
   logic [15:0] last_data = 16'h0000, dq_r = 16'h0000, v;
   logic [FL_ADDR_W-1:0] last_addr = '0;
   int busy_cnt = 0, left = 0, words = 0, xsr_reads = 0, proto_err = 0;
   wire logic [7:0] c = pins.dq_o[7:0]; // upper byte ignored
   assign rdy = busy_cnt == 0 || susp;
   assign sts = rdy; // low only while an algorithm runs
   assign dq = dq_r;
   always_comb begin
      case (mode)
         MODE_ARRAY: v = pins.addr[15:0] ^ 16'h5A5A;
         MODE_ID: v = ID_CODE ^ pins.addr[15:0];
         MODE_QUERY: v = {8'h00, pins.addr[7:0] + 8'h40};
         default: v = {8'h00, rdy && !(pend == 8'hE8 && xsr_reads == 0), 2'b00, err, 4'h0};
      endcase
   end
   // busy reads: only bit 7 valid, released bus never holds its last value
   always @(posedge pclk) begin
      if (!pins.ce_n && !pins.oe_n) begin
         dq_r <= rdy ? v : {~dq_r[15:8], v[7], ~dq_r[6:0]};
      end else begin
         dq_r <= ~dq_r;
      end
   end
   task automatic start(input logic ok);
      if (ok && pins.program_enable_supply_hv && (pins.rp_hv || pins.addr[22:17] != LOCK_BLK)) begin
         busy_cnt <= BUSY_CYC;
      end else begin
         err <= 1'b1; // failed or aborted sequence
      end
   endtask : start
   always @(posedge pclk) begin
      we_q <= pins.we_n;
      oe_q <= pins.oe_n;
      if (busy_cnt > 0 && !susp) begin
         busy_cnt <= busy_cnt - 1;
      end
      if (!oe_q && pins.oe_n && pend == 8'hE8) begin
         xsr_reads <= xsr_reads + 1;
      end
      if (!we_q && pins.we_n && pend == 8'h00) begin
         cmd1 <= c;
         case (c)
            8'hFF: if (rdy) mode <= MODE_ARRAY; // ignored while running
            8'h90: mode <= MODE_ID;
            8'h98: mode <= MODE_QUERY;
            8'h70: mode <= MODE_STATUS;
            8'h50: err <= 1'b0;
            8'hB0: susp <= busy_cnt > 0;
            8'hD0: susp <= 1'b0;
            8'hE8, 8'h40, 8'h10, 8'h20, 8'hB8, 8'h60: begin
               pend <= c;
               mode <= MODE_STATUS;
               xsr_reads <= 0;
            end
            default: proto_err <= proto_err + 1; // reserved code
         endcase
      end else if (!we_q && pins.we_n) begin
         cmd2 <= c;
         pend <= 8'h00;
         last_addr <= pins.addr;
         case (pend)
            8'hE8: begin
               if (c == 8'hE8) begin
                  pend <= 8'hE8;
               end else begin
                  if (xsr_reads < 2) proto_err <= proto_err + 1; // count before buffer ready
                  left <= int'(c[4:0]) + 1;
                  words <= 0;
                  pend <= 8'hE9;
               end
            end
            8'hE9: begin
               if (left > 0) begin
                  last_data <= pins.dq_o;
                  words <= words + 1;
                  left <= left - 1;
                  pend <= 8'hE9;
               end else begin
                  start(c == 8'hD0);
               end
            end
            8'h40, 8'h10: begin
               last_data <= pins.dq_o; // taken at strobe rise
               start(1'b1);
            end
            8'h20: start(c == 8'hD0);
            8'h60: start(c == 8'h01 || c == 8'hD0);
            default: cfg <= c;
         endcase
      end
   end
endmodule : fcd_flash_model

// file: tb_fcd_host.sv
/*
 testbench of the flash command host: apb orders against a flash model.
 assumes the package, host and model compiled before it.
*/
`timescale 1ns/1ps
module tb_fcd_host import fcd_pkg::*; ;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
   logic pready, pslverr, perr, sts;
   logic [FL_DATA_W-1:0] dq;
   fcd_pins_t fo;
   int failures = 0, n_checks = 0;
   fcd_host dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .flash_out(fo), .flash_dq_i(dq), .flash_sts(sts));
   fcd_flash_model flash_u (.pclk(pclk), .pins(fo), .dq(dq), .sts(sts));
   initial begin
      forever #20 pclk = ~pclk;
   end
   task automatic wrap_up;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : wrap_up
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      perr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         failures++;
         wrap_up();
      end
      @(posedge pclk);
   endtask : apb
   // start an order and poll until the sequencer is idle; rd keeps STATUS
   task automatic go(input logic [3:0] op);
      int n;
      apb(1'b1, REG_CTRL, (32'h0000_0001 << CTRL_GO_BIT) | 32'(op));
      n = 0;
      do begin
         apb(1'b0, REG_STATUS, 32'h0000_0000);
         n++;
      end while (rd[0] !== 1'b0 && n < 100);
      if (rd[0] !== 1'b0) begin
         failures++;
         wrap_up();
      end
   endtask : go
   task automatic wait_flash;
      int n;
      n = 0;
      while (sts !== 1'b1 && n < 400) begin
         @(posedge pclk);
         n++;
      end
      if (sts !== 1'b1) begin
         failures++;
         wrap_up();
      end
   endtask : wait_flash
   task automatic rdata(input string what, input logic [15:0] exp);
      apb(1'b0, REG_RDATA, 32'h0000_0000);
      check(what, 32'(rd[15:0]), 32'(exp));
   endtask : rdata
   task automatic t_reads;
      logic [15:0] exp [3] = '{16'h003D, 16'h0041, 16'h0080};
      check("pins idle", 32'({fo.ce_n, fo.oe_n, fo.we_n, fo.dq_oe}), 32'h0000_000E);
      apb(1'b0, REG_STATUS, 32'h0000_0000);
      check("mode after reset", 32'(rd[11:10]), 32'h0000_0000);
      apb(1'b1, REG_ADDR, 32'h0000_1234);
      go(4'hD);
      rdata("array read", 16'h486E);
      apb(1'b0, 8'h24, 32'h0000_0000);
      check("unmapped", 32'(perr), 32'h0000_0001);
      apb(1'b1, REG_ADDR, 32'h0000_0001);
      for (int i = 1; i <= 3; i++) begin
         go(4'(i));
         check("read mode", 32'(rd[11:10]), 32'(i));
         rdata("mode read", exp[i-1]);
      end
      go(4'h0);
      check("array cmd", 32'({flash_u.cmd1, 6'h00, rd[11:10]}), 32'h0000_FF00);
   endtask : t_reads
   task automatic t_program;
      apb(1'b1, REG_PINS, 32'h0000_0000);
      apb(1'b1, REG_ADDR, 32'h0000_0345);
      apb(1'b1, REG_DATA, 32'h0000_BEEF);
      go(4'h6);
      check("lockout refused", 32'(rd[2]), 32'h0000_0001);
      apb(1'b1, REG_PINS, 32'h0000_0001);
      go(4'h6);
      check("prog addr", 32'(flash_u.last_addr), 32'h0000_0345);
      check("prog data", 32'({flash_u.cmd1, flash_u.last_data}), 32'h0040_BEEF);
      check("busy seen", 32'({rd[4], rd[1]}), 32'h0000_0001);
      go(4'h0);
      check("array refused", 32'(rd[2]), 32'h0000_0001);
      go(4'h3);
      apb(1'b0, REG_RDATA, 32'h0000_0000);
      check("busy bit7", 32'(rd[7]), 32'h0000_0000);
      wait_flash();
      apb(1'b1, REG_ADDR, 32'h0002_0000);
      go(4'h6);
      go(4'h3);
      rdata("locked error", 16'h0090);
      go(4'h4);
      go(4'h3);
      rdata("error cleared", 16'h0080);
      apb(1'b1, REG_PINS, 32'h0000_0009);
      apb(1'b0, REG_STATUS, 32'h0000_0000);
      check("reset pin mode", 32'({fo.rp_n, rd[11:10]}), 32'h0000_0000);
      apb(1'b1, REG_PINS, 32'h0000_0001);
   endtask : t_program
   task automatic t_erase_lock;
      apb(1'b1, REG_ADDR, 32'h0004_0000);
      go(4'h7);
      check("erase seq", 32'({flash_u.cmd1, flash_u.cmd2}), 32'h0000_20D0);
      go(4'h8);
      check("suspended", 32'({flash_u.susp, sts}), 32'h0000_0003);
      go(4'h9);
      check("resumed", 32'({flash_u.susp, sts}), 32'h0000_0000);
      wait_flash();
      apb(1'b1, REG_ADDR, 32'h0000_0000);
      go(4'hB);
      check("lock set", 32'({flash_u.cmd1, flash_u.cmd2}), 32'h0000_6001);
      wait_flash();
      go(4'hC);
      check("lock clear", 32'({flash_u.cmd1, flash_u.cmd2}), 32'h0000_60D0);
      wait_flash();
      apb(1'b1, REG_DATA, 32'h0000_12A5);
      go(4'hA);
      check("config code", 32'({flash_u.cmd1, flash_u.cfg}), 32'h0000_B8A5);
   endtask : t_erase_lock
   task automatic t_buffer;
      for (int i = 0; i < 16; i++) begin
         apb(1'b1, REG_BUF + 8'(4 * i), 32'h0000_A000 + 32'(i));
      end
      apb(1'b1, REG_DATA, 32'h0000_0010);
      go(4'h5);
      check("count over max", 32'(rd[2]), 32'h0000_0001);
      apb(1'b1, REG_DATA, 32'h0000_000F);
      go(4'h5);
      check("xsr polled", 32'(flash_u.xsr_reads), 32'h0000_0002);
      check("buffer words", 32'(flash_u.words), 32'h0000_0010);
      check("last word", 32'(flash_u.last_data), 32'h0000_A00F);
      check("confirm starts", 32'({flash_u.err, sts, flash_u.cmd2}), 32'h0000_00D0);
      wait_flash();
      check("codes defined", 32'(flash_u.proto_err), 32'h0000_0000);
   endtask : t_buffer
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reads();
      t_program();
      t_erase_lock();
      t_buffer();
      wrap_up();
   end
endmodule : tb_fcd_host
